// ===== tb_tmw_timer.sv
/*
 * Self-checking bench for the 8-bit timer waveform block.
 * Assumes tmw_timer and tmw_pkg compiled first; no partner model.
 */
`timescale 1ns/1ps
module tb_tmw_timer;
    typedef struct {
        string name;
        logic [7:0] val;
    } tmw_tb_exp_type;

    logic ref_clk_i = 1'b0, rst_i = 1'b1, timer_tick_i = 1'b0;
    logic [2:0] waveform_mode_select_i = 3'h0;
    logic [1:0] compare_output_mode_a_i = 2'h0, compare_output_mode_b_i = 2'h0;
    logic count_wr_i = 1'b0, cmp_a_wr_i = 1'b0, cmp_b_wr_i = 1'b0;
    logic [7:0] count_wdata_i = 8'h00, cmp_wdata_i = 8'h00;
    logic force_compare_strobe_a_i = 1'b0, force_compare_strobe_b_i = 1'b0;
    logic flag_clr_ovf_i = 1'b0, flag_clr_a_i = 1'b0, flag_clr_b_i = 1'b0;
    logic ovf_serviced_i = 1'b0, cmp_a_serviced_i = 1'b0, cmp_b_serviced_i = 1'b0;
    logic port_a_value_i = 1'b0, port_b_value_i = 1'b0, dir_a_out_i = 1'b0, dir_b_out_i = 1'b0;
    logic [7:0] count_value_o, compare_value_a_o, compare_value_b_o;
    logic overflow_flag_o, compare_flag_a_o, compare_flag_b_o, compare_output_a_o, compare_output_b_o;
    logic pin_a_value_o, pin_a_oe_n_o, pin_b_value_o, pin_b_oe_n_o;
    int mismatches = 0;
    int n_checks = 0;
    tmw_tb_exp_type expq[$];
    tmw_tb_exp_type e;
    event obs_ev;
    logic [1:0] f_com [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
    logic [7:0] f_exp [4] = '{8'h00, 8'h01, 8'h01, 8'h01};

    tmw_timer i_tmw_timer (
        .ref_clk_i, .rst_i, .timer_tick_i, .waveform_mode_select_i,
        .compare_output_mode_a_i, .compare_output_mode_b_i, .count_wr_i, .count_wdata_i,
        .cmp_a_wr_i, .cmp_b_wr_i, .cmp_wdata_i, .force_compare_strobe_a_i, .force_compare_strobe_b_i,
        .flag_clr_ovf_i, .flag_clr_a_i, .flag_clr_b_i, .ovf_serviced_i, .cmp_a_serviced_i,
        .cmp_b_serviced_i, .port_a_value_i, .port_b_value_i, .dir_a_out_i, .dir_b_out_i,
        .count_value_o, .compare_value_a_o, .compare_value_b_o, .overflow_flag_o, .compare_flag_a_o,
        .compare_flag_b_o, .compare_output_a_o, .compare_output_b_o, .pin_a_value_o, .pin_a_oe_n_o,
        .pin_b_value_o, .pin_b_oe_n_o
    );

    always #10 ref_clk_i = ~ref_clk_i;

    function automatic logic [7:0] seen_of(input string name);
        case (name)
            "count": return count_value_o;
            "cmp_a": return compare_value_a_o;
            "ovf": return {7'h00, overflow_flag_o};
            "flag_a": return {7'h00, compare_flag_a_o};
            "flag_b": return {7'h00, compare_flag_b_o};
            "cmp_b": return compare_value_b_o;
            "oc_a": return {7'h00, compare_output_a_o};
            "oc_b": return {7'h00, compare_output_b_o};
            "pin_a": return {7'h00, pin_a_value_o};
            "oe_a": return {7'h00, pin_a_oe_n_o};
            "pin_b": return {7'h00, pin_b_value_o};
            "oe_b": return {7'h00, pin_b_oe_n_o};
            default: return 8'hXX;
        endcase
    endfunction

    task automatic check_val(input string name, input logic [7:0] seen, input logic [7:0] exp_v);
        n_checks++;
        if (seen !== exp_v) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp_v, seen);
        end
    endtask

    // Result watcher: every queued note, oldest first, against outputs
    always begin
        @(obs_ev);
        while (expq.size() > 0) begin
            e = expq.pop_front();
            check_val(e.name, seen_of(e.name), e.val);
        end
    end

    task automatic note(input string name, input logic [7:0] v);
        expq.push_back('{name, v});
    endtask

    task automatic obs();
        #2;
        -> obs_ev;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask

    task automatic run(input int n);
        timer_tick_i = 1'b1;
        cyc(n);
        timer_tick_i = 1'b0;
    endtask

    task automatic wr_count(input logic [7:0] v);
        count_wdata_i = v;
        pulse(count_wr_i);
    endtask

    task automatic wr_cmp(input bit to_a, input logic [7:0] v);
        cmp_wdata_i = v;
        if (to_a) begin
            pulse(cmp_a_wr_i);
        end else begin
            pulse(cmp_b_wr_i);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        mismatches++;
        $display("watchdog expired");
        complete_run();
    end

    initial begin
        void'($urandom(32'hD46B205D));
        cyc(20);
        rst_i = 1'b0;
        note("count", 8'h00); note("oc_a", 8'h00); note("oc_b", 8'h00);
        note("ovf", 8'h00); note("cmp_a", 8'h00); obs();
        $display("test reset done");
        wr_count(8'hFE);
        run(1); note("count", 8'hFF); note("ovf", 8'h00); obs();
        run(1); note("count", 8'h00); note("ovf", 8'h01); obs();
        cyc(5); note("count", 8'h00); obs();
        pulse(ovf_serviced_i); note("ovf", 8'h00); obs();
        run(1); note("flag_a", 8'h01); obs();
        pulse(flag_clr_a_i); note("flag_a", 8'h00); obs();
        $display("test normal done");
        waveform_mode_select_i = 3'h2;
        compare_output_mode_a_i = 2'h1;
        wr_cmp(1'b1, 8'h02); note("cmp_a", 8'h02); obs();
        wr_count(8'h00);
        run(2); note("count", 8'h02); note("flag_a", 8'h00); obs();
        run(1); note("count", 8'h00); note("flag_a", 8'h01); note("oc_a", 8'h01); obs();
        pulse(flag_clr_a_i);
        wr_count(8'h05);
        wr_cmp(1'b1, 8'h03);
        run(250); note("count", 8'hFF); note("ovf", 8'h00); obs();
        run(1); note("count", 8'h00); note("ovf", 8'h01); obs();
        run(4); note("count", 8'h00); note("flag_a", 8'h01); note("oc_a", 8'h00); obs();
        pulse(flag_clr_a_i);
        pulse(flag_clr_ovf_i); note("ovf", 8'h00); obs();
        compare_output_mode_a_i = 2'h3;
        run(4); note("count", 8'h00); note("oc_a", 8'h01); obs();
        pulse(flag_clr_a_i);
        $display("test clear_on_match done");
        waveform_mode_select_i = 3'h0;
        for (int i = 0; i < 4; i++) begin
            compare_output_mode_a_i = f_com[i];
            pulse(force_compare_strobe_a_i);
            note("oc_a", f_exp[i]); note("flag_a", 8'h00); note("count", 8'h00); obs();
        end
        waveform_mode_select_i = 3'h3;
        compare_output_mode_a_i = 2'h2;
        pulse(force_compare_strobe_a_i); note("oc_a", 8'h01); obs();
        $display("test force done");
        for (int i = 0; i < 12; i++) begin
            waveform_mode_select_i = (i % 3 == 2) ? 3'h3 : 3'(2 * (i % 3));
            compare_output_mode_a_i = 2'(i / 3);
            compare_output_mode_b_i = 2'(i / 3);
            {port_a_value_i, port_b_value_i, dir_a_out_i, dir_b_out_i} = 4'($urandom());
            note("pin_a", (i / 3 != 0) ? 8'h01 : {7'h00, port_a_value_i});
            note("oe_a", {7'h00, ~dir_a_out_i});
            note("pin_b", (i / 3 != 0) ? 8'h00 : {7'h00, port_b_value_i});
            note("oe_b", {7'h00, ~dir_b_out_i});
            obs();
            cyc(1);
        end
        $display("test pin override done");
        waveform_mode_select_i = 3'h3;
        compare_output_mode_a_i = 2'h2;
        compare_output_mode_b_i = 2'h3;
        wr_count(8'hFD);
        wr_cmp(1'b1, 8'h80);
        wr_cmp(1'b0, 8'h40); note("cmp_a", 8'h03); obs();
        run(2); note("count", 8'hFF); obs();
        run(1); note("count", 8'h00); note("ovf", 8'h01); note("cmp_a", 8'h80); obs();
        note("oc_a", 8'h01); note("oc_b", 8'h00); obs();
        pulse(flag_clr_b_i); note("flag_b", 8'h00); note("cmp_b", 8'h40); obs();
        run(8'h41); note("count", 8'h41); note("oc_b", 8'h01); note("flag_b", 8'h01); obs();
        run(8'h40); note("count", 8'h81); note("oc_a", 8'h00); note("flag_a", 8'h01); obs();
        $display("test fast pwm done");
        waveform_mode_select_i = 3'h7;
        compare_output_mode_a_i = 2'h1;
        compare_output_mode_b_i = 2'h1;
        wr_count(8'h00);
        wr_cmp(1'b1, 8'h04);
        run(8'h81); note("count", 8'h00); note("oc_a", 8'h01); note("oc_b", 8'h01); obs();
        run(5); note("count", 8'h00); note("oc_a", 8'h00); note("cmp_a", 8'h04); obs();
        $display("test pwm top a done");
        complete_run();
    end
endmodule

// ===== tmw_cmp_buf.sv
/*
 * Compare value holder: direct in non-PWM modes, double buffered and
 * loaded at the top in single-slope PWM.
 * Assumes writes are one-cycle strobes synchronous to ref_clk_i.
 */
`timescale 1ns/1ps
module tmw_cmp_buf (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic buffered_i,
    input wire logic load_i,
    output logic [7:0] value_o
);
    logic [7:0] buf_r;
    logic [7:0] value_r;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            buf_r <= tmw_pkg::CMP_RST;
        end else if (wr_i) begin
            buf_r <= wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            value_r <= tmw_pkg::CMP_RST;
        end else if (!buffered_i && wr_i) begin
            value_r <= wdata_i;
        end else if (buffered_i && load_i) begin
            value_r <= buf_r;
        end
    end

    assign value_o = value_r;
endmodule

// ===== tmw_out_unit.sv
/*
 * One compare output unit: output state register and pin override.
 * Assumes match, bottom and force qualifiers come from the counter core.
 */
`timescale 1ns/1ps
module tmw_out_unit #(
    parameter bit HAS_TOGGLE_PWM = 1'b1
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [1:0] compare_output_mode_bits_i,
    input wire logic fast_i,
    input wire logic waveform_mode_bit2_i,
    input wire logic match_i,
    input wire logic bottom_i,
    input wire logic force_i,
    input wire logic port_value_i,
    input wire logic pin_dir_out_i,
    output logic compare_output_state_o,
    output logic pin_value_o,
    output logic pin_oe_n_o
);
    logic state_r;
    logic state_nxt;
    logic [1:0] com;

    assign com = compare_output_mode_bits_i;

    always_comb begin
        state_nxt = state_r;
        if (fast_i) begin
            if (match_i) begin
                if (com == tmw_pkg::COM_CLEAR) begin
                    state_nxt = 1'b0;
                end else if (com == tmw_pkg::COM_SET) begin
                    state_nxt = 1'b1;
                end else if (com == tmw_pkg::COM_TOGGLE && HAS_TOGGLE_PWM && waveform_mode_bit2_i) begin
                    state_nxt = ~state_r;
                end
            end
            if (bottom_i) begin
                if (com == tmw_pkg::COM_CLEAR) begin
                    state_nxt = 1'b1;
                end else if (com == tmw_pkg::COM_SET) begin
                    state_nxt = 1'b0;
                end
            end
        end else if (match_i || force_i) begin
            case (com)
                tmw_pkg::COM_TOGGLE: state_nxt = ~state_r;
                tmw_pkg::COM_CLEAR: state_nxt = 1'b0;
                tmw_pkg::COM_SET: state_nxt = 1'b1;
                default: state_nxt = state_r;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_r <= tmw_pkg::OC_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign pin_value_o = (com != tmw_pkg::COM_OFF) ? state_r : port_value_i;
    assign pin_oe_n_o = ~pin_dir_out_i;
    assign compare_output_state_o = state_r;

    AST_OVERRIDE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (com != tmw_pkg::COM_OFF) |-> pin_value_o == state_r) else $error("override wrong");
    AST_NO_ACTION: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (com == tmw_pkg::COM_OFF && !bottom_i) |=> $stable(state_r)) else $error("state moved");
endmodule

// ===== tmw_pkg.sv
/*
 * Package for the 8-bit timer waveform block: mode codes, compare
 * output actions, widths and reset values.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tmw_pkg;
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic OC_RST = 1'h0;
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    localparam int WGM_BIT2 = 2;

    typedef enum logic [2:0] {
        WGM_NORMAL = 3'h0,
        WGM_PC_MAX = 3'h1,
        WGM_CTC = 3'h2,
        WGM_FAST_MAX = 3'h3,
        WGM_RSV4 = 3'h4,
        WGM_PC_OCRA = 3'h5,
        WGM_RSV6 = 3'h6,
        WGM_FAST_OCRA = 3'h7
    } tmw_wgm_type;

    // Single-slope PWM modes
    function automatic logic tmw_is_fast(input logic [2:0] wgm);
        return (wgm == WGM_FAST_MAX) || (wgm == WGM_FAST_OCRA);
    endfunction
endpackage

// ===== tmw_timer.sv
/*
 * 8-bit timer counter with normal, clear-on-match and single-slope PWM
 * counting, compare flags, overflow flag and two compare outputs.
 * Assumes a one-cycle timer clock enable from the prescaler and
 * one-cycle write strobes, all synchronous to ref_clk_i.
 */
`timescale 1ns/1ps
module tmw_timer (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic timer_tick_i,
    input wire logic [2:0] waveform_mode_select_i,
    input wire logic [1:0] compare_output_mode_a_i,
    input wire logic [1:0] compare_output_mode_b_i,
    input wire logic count_wr_i,
    input wire logic [7:0] count_wdata_i,
    input wire logic cmp_a_wr_i,
    input wire logic cmp_b_wr_i,
    input wire logic [7:0] cmp_wdata_i,
    input wire logic force_compare_strobe_a_i,
    input wire logic force_compare_strobe_b_i,
    input wire logic flag_clr_ovf_i,
    input wire logic flag_clr_a_i,
    input wire logic flag_clr_b_i,
    input wire logic ovf_serviced_i,
    input wire logic cmp_a_serviced_i,
    input wire logic cmp_b_serviced_i,
    input wire logic port_a_value_i,
    input wire logic port_b_value_i,
    input wire logic dir_a_out_i,
    input wire logic dir_b_out_i,
    output logic [7:0] count_value_o,
    output logic [7:0] compare_value_a_o,
    output logic [7:0] compare_value_b_o,
    output logic overflow_flag_o,
    output logic compare_flag_a_o,
    output logic compare_flag_b_o,
    output logic compare_output_a_o,
    output logic compare_output_b_o,
    output logic pin_a_value_o,
    output logic pin_a_oe_n_o,
    output logic pin_b_value_o,
    output logic pin_b_oe_n_o
);
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic ovf_r;
    logic flag_a_r;
    logic flag_b_r;
    logic block_r;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [7:0] top;
    logic fast;
    logic clear_on_match_mode;
    logic at_top;
    logic eq_a;
    logic eq_b;
    logic match_a;
    logic match_b;
    logic wrap;
    logic ovf_set;
    logic force_ok;

    assign fast = tmw_pkg::tmw_is_fast(waveform_mode_select_i);
    assign clear_on_match_mode = (waveform_mode_select_i == tmw_pkg::WGM_CTC);
    assign top = (waveform_mode_select_i == tmw_pkg::WGM_FAST_OCRA || clear_on_match_mode) ? cmp_a : tmw_pkg::CNT_MAX;
    assign at_top = (count_r == top);
    assign eq_a = (count_r == cmp_a) && !block_r;
    assign eq_b = (count_r == cmp_b) && !block_r;
    assign match_a = timer_tick_i && eq_a;
    assign match_b = timer_tick_i && eq_b;
    assign wrap = timer_tick_i && fast && at_top;
    assign force_ok = !fast;

    always_comb begin
        count_nxt = count_r + 8'h01;
        ovf_set = 1'b0;
        case (waveform_mode_select_i)
            tmw_pkg::WGM_NORMAL: begin
                ovf_set = (count_r == tmw_pkg::CNT_MAX);
            end
            tmw_pkg::WGM_CTC: begin
                ovf_set = (count_r == tmw_pkg::CNT_MAX);
                if (eq_a) begin
                    count_nxt = tmw_pkg::CNT_BOTTOM;
                end
            end
            tmw_pkg::WGM_FAST_MAX, tmw_pkg::WGM_FAST_OCRA: begin
                ovf_set = at_top;
                if (at_top) begin
                    count_nxt = tmw_pkg::CNT_BOTTOM;
                end
            end
            default: begin
                ovf_set = (count_r == tmw_pkg::CNT_MAX);
            end
        endcase
    end

    // Counter; software write has priority
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            count_r <= tmw_pkg::CNT_BOTTOM;
        end else if (count_wr_i) begin
            count_r <= count_wdata_i;
        end else if (timer_tick_i) begin
            count_r <= count_nxt;
        end
    end

    // Count write blocks matches for one timer cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            block_r <= 1'b0;
        end else if (count_wr_i) begin
            block_r <= 1'b1;
        end else if (timer_tick_i) begin
            block_r <= 1'b0;
        end
    end

    // Overflow flag only set by counting
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ovf_r <= 1'b0;
        end else if (timer_tick_i && ovf_set) begin
            ovf_r <= 1'b1;
        end else if (ovf_serviced_i || flag_clr_ovf_i) begin
            ovf_r <= 1'b0;
        end
    end

    // Flag on the next timer cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            flag_a_r <= 1'b0;
            flag_b_r <= 1'b0;
        end else begin
            if (match_a) begin
                flag_a_r <= 1'b1;
            end else if (flag_clr_a_i || cmp_a_serviced_i) begin
                flag_a_r <= 1'b0;
            end
            if (match_b) begin
                flag_b_r <= 1'b1;
            end else if (flag_clr_b_i || cmp_b_serviced_i) begin
                flag_b_r <= 1'b0;
            end
        end
    end

    // Buffered in single-slope PWM, loaded at top
    tmw_cmp_buf u_cmp_a (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .wr_i(cmp_a_wr_i),
        .wdata_i(cmp_wdata_i),
        .buffered_i(fast),
        .load_i(wrap),
        .value_o(cmp_a)
    );

    tmw_cmp_buf u_cmp_b (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .wr_i(cmp_b_wr_i),
        .wdata_i(cmp_wdata_i),
        .buffered_i(fast),
        .load_i(wrap),
        .value_o(cmp_b)
    );

    // Top match ignored when set or clear at bottom
    tmw_out_unit #(.HAS_TOGGLE_PWM(1'b1)) u_out_a (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .compare_output_mode_bits_i(compare_output_mode_a_i),
        .fast_i(fast),
        .waveform_mode_bit2_i(waveform_mode_select_i[tmw_pkg::WGM_BIT2]),
        .match_i(match_a && !(fast && at_top && compare_output_mode_a_i[1])),
        .bottom_i(wrap),
        .force_i(force_ok && force_compare_strobe_a_i),
        .port_value_i(port_a_value_i),
        .pin_dir_out_i(dir_a_out_i),
        .compare_output_state_o(compare_output_a_o),
        .pin_value_o(pin_a_value_o),
        .pin_oe_n_o(pin_a_oe_n_o)
    );

    tmw_out_unit #(.HAS_TOGGLE_PWM(1'b0)) u_out_b (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .compare_output_mode_bits_i(compare_output_mode_b_i),
        .fast_i(fast),
        .waveform_mode_bit2_i(waveform_mode_select_i[tmw_pkg::WGM_BIT2]),
        .match_i(match_b && !(fast && at_top && compare_output_mode_b_i[1])),
        .bottom_i(wrap),
        .force_i(force_ok && force_compare_strobe_b_i),
        .port_value_i(port_b_value_i),
        .pin_dir_out_i(dir_b_out_i),
        .compare_output_state_o(compare_output_b_o),
        .pin_value_o(pin_b_value_o),
        .pin_oe_n_o(pin_b_oe_n_o)
    );

    assign count_value_o = count_r;
    assign compare_value_a_o = cmp_a;
    assign compare_value_b_o = cmp_b;
    assign overflow_flag_o = ovf_r;
    assign compare_flag_a_o = flag_a_r;
    assign compare_flag_b_o = flag_b_r;

    sequence s_pwm_top;
        timer_tick_i && fast && at_top && !count_wr_i;
    endsequence

    AST_NORMAL_WRAP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (timer_tick_i && !count_wr_i && waveform_mode_select_i == tmw_pkg::WGM_NORMAL && count_r == 8'hFF)
        |=> count_r == 8'h00 && ovf_r) else $error("normal wrap wrong");
    AST_CTC_CLEAR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (timer_tick_i && !count_wr_i && clear_on_match_mode && eq_a) |=> count_r == 8'h00 && flag_a_r)
        else $error("ctc clear wrong");
    AST_PWM_TOP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_pwm_top |=> count_r == 8'h00 && ovf_r) else $error("pwm top wrong");
    AST_FLAG_A: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        match_a |=> flag_a_r) else $error("flag a not set");
    AST_FLAG_CLR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (flag_clr_b_i && !match_b) |=> !flag_b_r) else $error("flag b not cleared");
    AST_OVF_SVC: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (ovf_serviced_i && !(timer_tick_i && ovf_set)) |=> !ovf_r) else $error("ovf not cleared");
    AST_NO_TICK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!timer_tick_i && !count_wr_i) |=> $stable(count_r) && $stable(compare_output_a_o)
        || $past(force_compare_strobe_a_i)) else $error("change without tick");
    AST_FORCE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (force_compare_strobe_a_i && !fast && !timer_tick_i && !count_wr_i && compare_output_mode_a_i == 2'h3)
        |=> compare_output_a_o && $stable(count_r) && ($stable(flag_a_r) || !flag_a_r))
        else $error("force wrong");
endmodule
